// [core/dsc_pkg.sv]
`default_nettype none
package dsc_pkg;
  // time base: one tick every 10 ms
  localparam int CLK_NS       = 10;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYC_DEF = TICK_MS * 1000000 / CLK_NS;
  localparam int RST_MIN_MS   = 500;
  localparam int RST_MAX_MS   = 10000;
  localparam int DEACT_MS     = 20000;
  localparam int RLY_DROP_MS  = 1000;
  localparam int SEC_MS       = 1000;
  localparam int LINK_TMO_MS  = 5000;
  localparam logic [11:0] RST_MIN_TK = 12'((RST_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [11:0] RST_MAX_TK = 12'(RST_MAX_MS / TICK_MS);
  localparam logic [11:0] DEACT_TK   = 12'(DEACT_MS / TICK_MS);
  localparam logic [6:0]  RLY_TK     = 7'(RLY_DROP_MS / TICK_MS);
  localparam logic [6:0]  SEC_TK     = 7'(SEC_MS / TICK_MS);
  localparam logic [9:0]  LINK_TK    = 10'(LINK_TMO_MS / TICK_MS);
  // airflow and level threshold defaults (all switches off)
  localparam logic [7:0]  AF_WIN_DEF = 8'h14;
  localparam logic [15:0] AF_DLY_DEF = 16'h012c;
  localparam logic [31:0] THR_DEF    = 32'hc0_80_60_40;
  // storage sizes and event code high nibble
  localparam logic [9:0]  EVT_DEPTH  = 10'h3e8;
  localparam logic [14:0] LOG_ENTRY  = 15'h7080;
  localparam logic [7:0]  LOG_FILES  = 8'hfb;
  localparam logic [15:0] EVT_ENTRY  = 16'hfa00;
  localparam logic [3:0]  EVT_FILES  = 4'ha;
  localparam logic [3:0]  EVT_CODE_HI = 4'h1;
  // privileged erase key, value arbitrary
  localparam logic [31:0] ERASE_KEY  = 32'h5a3c_0f96;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_AFCFG = 8'h08;
  localparam logic [7:0] A_THR   = 8'h0c;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_AFREF = 8'h14;
  localparam logic [7:0] A_EVCNT = 8'h18;
  localparam logic [7:0] A_EVIDX = 8'h1c;
  localparam logic [7:0] A_EVDAT = 8'h20;
  localparam logic [7:0] A_FILES = 8'h24;
  localparam logic [7:0] A_ERASE = 8'h28;
  // event bit positions
  localparam int EV_ALM  = 0;
  localparam int EV_PRE1 = 1;
  localparam int EV_AFLO = 4;
  localparam int EV_AFHI = 5;
  localparam int EV_FAN  = 6;
  localparam int EV_INIT = 7;
  localparam int EV_SELE = 8;
  localparam int EV_SDST = 9;
  localparam int EV_LINK = 10;
  localparam int EV_MOD  = 11;
  localparam int EV_MCU  = 12;
  localparam int EV_UV   = 13;
  localparam int EV_DEAC = 14;
  localparam int EV_ISO  = 15;
  localparam logic [15:0] FLT_MASK = 16'hfff0;
  typedef struct packed {
    logic       valid;
    logic       elec_flt;
    logic       dusty;
    logic [7:0] level;
  } dsc_sns_t;
  typedef struct packed {
    logic       isolate;
    logic       loop_fitted;
    logic [7:0] af_win;
    logic [15:0] af_dly;
    logic [31:0] thr;
  } dsc_cfg_t;
endpackage
`default_nettype wire

// [core/dsc_top.sv]
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - 0.5-10 s external pulse requests state reset
// - external input held over 20 s deactivates
// - no deactivation when loop module fitted
// - initial reset captures airflow as reference
// - airflow out of window for delay: fault
// - defaults: plus/minus 20 percent, 300 s
// - sensor failure, dust and link loss flagged
// - sensor levels raise alarm or pre-signals
// - isolation blocks alarm relays and outputs
// - isolation raises fault, indicator stays lit
// - fault drops relay, lights fault indicator
// - listed causes each raise a fault
// - no fault outside restart keeps fault relay energised
// - 1000 entry memory, newest first, wraps
// - only privileged key erases event memory
// - log each second, 28800 per file, 251
// - events to file, 64000 per file, 10
// - events latch until state reset
// - reset only after event, condition normal
// - restart key stops fan, keeps configuration
// - restart drops fault relay about 1 s
// - reference kept until next initial reset
module dsc_top import dsc_pkg::*; #(
  parameter int unsigned P_TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_AWVALID,
  output var  logic        O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output var  logic        O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output var  logic        O_BVALID,
  input  wire logic        I_BREADY,
  output var  logic [1:0]  O_BRESP,
  input  wire logic        I_ARVALID,
  output var  logic        O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output var  logic        O_RVALID,
  input  wire logic        I_RREADY,
  output var  logic [31:0] O_RDATA,
  output var  logic [1:0]  O_RRESP,
  input  wire logic        I_EXT_RST,
  input  wire logic [15:0] I_AIRFLOW,
  input  wire dsc_sns_t    I_SNS,
  input  wire logic        I_FAN_FLT,
  input  wire logic        I_MOD_FLT,
  input  wire logic        I_MCU_FLT,
  input  wire logic        I_UNDERVOLT,
  output var  logic        O_FLT_RELAY,
  output var  logic        O_FLT_LED,
  output var  logic        O_OC_FLT,
  output var  logic        O_ALM_RELAY,
  output var  logic        O_OC_ALM,
  output var  logic        O_LOOP_ALM,
  output var  logic [2:0]  O_LOOP_PRE,
  output var  logic        O_FAN_RUN,
  output var  logic [7:0]  O_FAN_SPD,
  output var  logic        O_LOG_STB,
  output var  logic [7:0]  O_LOG_FILE,
  output var  logic        O_EVT_STB,
  output var  logic [7:0]  O_EVT_CODE,
  output var  logic [3:0]  O_EVT_FILE
);
  logic [19:0] tk_cnt_q;
  logic        tick_q;
  logic [6:0]  sec_cnt_q;
  logic        sec_q;
  logic        awrdy_q, wrdy_q, aw_ok_q, w_ok_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        do_wr, wr_map;
  logic [31:0] rd_mux;
  logic        rd_map;
  dsc_cfg_t    cfg_q;
  logic        key_q, init_q, hwk_q, erase_q;
  logic [9:0]  evidx_q;
  logic [11:0] ext_cnt_q;
  logic        ext_prev_q, ext_req_q, deact_q;
  logic        restart_q;
  logic [6:0]  rs_cnt_q;
  logic [15:0] ref_q;
  logic        ref_ok_q;
  logic [23:0] a100, lo_l, hi_l;
  logic        af_lo, af_hi;
  logic [15:0] af_sec_q;
  logic [7:0]  lvl_q;
  logic        sele_q, sdst_q;
  logic [9:0]  lnk_cnt_q;
  logic [15:0] cond, ev_q, ev_d, clr, pend_q;
  logic        accept;
  logic [3:0]  pk_idx;
  logic        pk_any;
  logic [7:0]  mem [0:999];
  logic [9:0]  wp_q, ecnt_q;
  logic [10:0] rd_sum;
  logic [9:0]  rd_addr;
  logic [15:0] evf_cnt_q;
  logic [14:0] log_cnt_q;
  logic        fault, iso;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // 10 ms tick and 1 s strobe
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tk_cnt_q <= '0;
      tick_q   <= 1'b0;
    end else if (tk_cnt_q == 20'(P_TICK_CYC - 1)) begin
      tk_cnt_q <= '0;
      tick_q   <= 1'b1;
    end else begin
      tk_cnt_q <= tk_cnt_q + 20'h1;
      tick_q   <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sec_cnt_q <= '0;
      sec_q     <= 1'b0;
    end else begin
      sec_q <= 1'b0;
      if (tick_q) begin
        if (sec_cnt_q == SEC_TK - 7'h1) begin
          sec_cnt_q <= '0;
          sec_q     <= 1'b1;
        end else begin
          sec_cnt_q <= sec_cnt_q + 7'h1;
        end
      end
    end
  end

  // write address and data taken in either order, answered together
  assign do_wr = aw_ok_q & w_ok_q & ~O_BVALID;
  assign wr_map = (awa_q == A_CTRL) | (awa_q == A_CMD) | (awa_q == A_AFCFG) | (awa_q == A_THR)
                | (awa_q == A_EVIDX) | (awa_q == A_ERASE);
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      awrdy_q  <= 1'b1;
      wrdy_q   <= 1'b1;
      aw_ok_q  <= 1'b0;
      w_ok_q   <= 1'b0;
      awa_q    <= '0;
      wd_q     <= '0;
      ws_q     <= '0;
      O_BVALID <= 1'b0;
      O_BRESP  <= 2'h0;
    end else begin
      if (I_AWVALID & awrdy_q) begin
        awrdy_q <= 1'b0;
        aw_ok_q <= 1'b1;
        awa_q   <= {I_AWADDR[7:2], 2'h0};
      end
      if (I_WVALID & wrdy_q) begin
        wrdy_q <= 1'b0;
        w_ok_q <= 1'b1;
        wd_q   <= I_WDATA;
        ws_q   <= I_WSTRB;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_map ? 2'h0 : 2'h2;
      end
      if (O_BVALID & I_BREADY) begin
        O_BVALID <= 1'b0;
        aw_ok_q  <= 1'b0;
        w_ok_q   <= 1'b0;
        awrdy_q  <= 1'b1;
        wrdy_q   <= 1'b1;
      end
    end
  end
  assign O_AWREADY = awrdy_q;
  assign O_WREADY  = wrdy_q;

  // configuration registers and command pulses; restart keeps them
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cfg_q   <= '{isolate: 1'b0, loop_fitted: 1'b0, af_win: AF_WIN_DEF, af_dly: AF_DLY_DEF, thr: THR_DEF};
      key_q   <= 1'b0;
      init_q  <= 1'b0;
      hwk_q   <= 1'b0;
      erase_q <= 1'b0;
      evidx_q <= 10'h1;
    end else begin
      key_q   <= 1'b0;
      init_q  <= 1'b0;
      hwk_q   <= 1'b0;
      erase_q <= 1'b0;
      if (do_wr) begin
        case (awa_q)
          A_CTRL: begin
            if (ws_q[0]) begin
              cfg_q.isolate     <= wd_q[0];
              cfg_q.loop_fitted <= wd_q[1];
            end
          end
          A_CMD: begin
            if (ws_q[0]) begin
              key_q  <= wd_q[0];
              init_q <= wd_q[1];
              hwk_q  <= wd_q[2];
            end
          end
          A_AFCFG: begin
            {cfg_q.af_dly, cfg_q.af_win} <= 24'(merge({8'h0, cfg_q.af_dly, cfg_q.af_win}, wd_q, ws_q));
          end
          A_THR: cfg_q.thr <= merge(cfg_q.thr, wd_q, ws_q);
          A_EVIDX: evidx_q <= 10'(merge({22'h0, evidx_q}, wd_q, ws_q));
          A_ERASE: erase_q <= (wd_q == ERASE_KEY) & (ws_q == 4'hf);
          default: ;
        endcase
      end
    end
  end

  // read path, data registered with the handshake
  assign rd_sum  = {1'b0, wp_q} + {1'b0, EVT_DEPTH} - {1'b0, evidx_q};
  assign rd_addr = (rd_sum >= {1'b0, EVT_DEPTH}) ? 10'(rd_sum - {1'b0, EVT_DEPTH}) : rd_sum[9:0];
  always_comb begin
    rd_mux = '0;
    rd_map = 1'b1;
    case ({I_ARADDR[7:2], 2'h0})
      A_CTRL:  rd_mux = {30'h0, cfg_q.loop_fitted, cfg_q.isolate};
      A_CMD:   rd_mux = '0;
      A_AFCFG: rd_mux = {8'h0, cfg_q.af_dly, cfg_q.af_win};
      A_THR:   rd_mux = cfg_q.thr;
      A_STAT:  rd_mux = {cond, ev_q};
      A_AFREF: rd_mux = {15'h0, ref_ok_q, ref_q};
      A_EVCNT: rd_mux = {22'h0, ecnt_q};
      A_EVIDX: rd_mux = {22'h0, evidx_q};
      A_EVDAT: rd_mux = {23'h0, (evidx_q != 10'h0) & (evidx_q <= ecnt_q), mem[rd_addr]};
      A_FILES: rd_mux = {20'h0, O_EVT_FILE, O_LOG_FILE};
      A_ERASE: rd_mux = '0;
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= '0;
      O_RRESP   <= 2'h0;
    end else if (I_ARVALID & O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_mux;
      O_RRESP   <= rd_map ? 2'h0 : 2'h2;
    end else if (O_RVALID & I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // external reset input measured in ticks on release
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ext_cnt_q  <= '0;
      ext_prev_q <= 1'b0;
      ext_req_q  <= 1'b0;
      deact_q    <= 1'b0;
    end else begin
      ext_prev_q <= I_EXT_RST;
      ext_req_q  <= 1'b0;
      if (I_EXT_RST) begin
        if (tick_q & (ext_cnt_q != 12'hfff)) begin
          ext_cnt_q <= ext_cnt_q + 12'h1;
        end
        if ((ext_cnt_q > DEACT_TK) & ~cfg_q.loop_fitted) begin
          deact_q <= 1'b1;
        end
      end else begin
        ext_cnt_q <= '0;
        deact_q   <= 1'b0;
        if (ext_prev_q) begin
          ext_req_q <= (ext_cnt_q >= RST_MIN_TK) & (ext_cnt_q <= RST_MAX_TK);
        end
      end
    end
  end

  // restart: relay drops about 1 s, fan stops then ramps
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      restart_q <= 1'b1;
      rs_cnt_q  <= '0;
    end else if (hwk_q) begin
      restart_q <= 1'b1;
      rs_cnt_q  <= '0;
    end else if (restart_q & tick_q) begin
      rs_cnt_q <= rs_cnt_q + 7'h1;
      if (rs_cnt_q == RLY_TK - 7'h1) begin
        restart_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FAN_RUN <= 1'b0;
      O_FAN_SPD <= '0;
    end else begin
      O_FAN_RUN <= ~restart_q;
      if (restart_q) begin
        O_FAN_SPD <= '0;
      end else if (tick_q & (O_FAN_SPD != 8'hff)) begin
        O_FAN_SPD <= O_FAN_SPD + 8'h1;
      end
    end
  end

  // airflow reference, kept until the next initial reset
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ref_q    <= '0;
      ref_ok_q <= 1'b0;
    end else if (init_q) begin
      ref_q    <= I_AIRFLOW;
      ref_ok_q <= 1'b1;
    end
  end

  // window centred on the reference, compared scaled by 100
  assign a100  = 24'(I_AIRFLOW) * 24'h64;
  assign lo_l  = 24'(ref_q) * (24'h64 - 24'(cfg_q.af_win));
  assign hi_l  = 24'(ref_q) * (24'h64 + 24'(cfg_q.af_win));
  assign af_lo = ref_ok_q & (a100 < lo_l);
  assign af_hi = ref_ok_q & (a100 > hi_l);
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      af_sec_q <= '0;
    end else if (~(af_lo | af_hi) | init_q) begin
      af_sec_q <= '0;
    end else if (sec_q & (af_sec_q < cfg_q.af_dly)) begin
      af_sec_q <= af_sec_q + 16'h1;
    end
  end

  // sensor frames and link watchdog
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lvl_q     <= '0;
      sele_q    <= 1'b0;
      sdst_q    <= 1'b0;
      lnk_cnt_q <= '0;
    end else if (I_SNS.valid) begin
      lvl_q     <= I_SNS.level;
      sele_q    <= I_SNS.elec_flt;
      sdst_q    <= I_SNS.dusty;
      lnk_cnt_q <= '0;
    end else if (tick_q & (lnk_cnt_q != LINK_TK)) begin
      lnk_cnt_q <= lnk_cnt_q + 10'h1;
    end
  end

  // live conditions, one bit per event
  always_comb begin
    cond          = '0;
    cond[EV_ALM]  = lvl_q > cfg_q.thr[31:24];
    for (int p = 0; p < 3; p++) begin
      cond[EV_PRE1 + p] = lvl_q > cfg_q.thr[p*8 +: 8];
    end
    cond[EV_AFLO] = af_lo & (af_sec_q >= cfg_q.af_dly);
    cond[EV_AFHI] = af_hi & (af_sec_q >= cfg_q.af_dly);
    cond[EV_FAN]  = I_FAN_FLT;
    cond[EV_INIT] = ~ref_ok_q;
    cond[EV_SELE] = sele_q;
    cond[EV_SDST] = sdst_q;
    cond[EV_LINK] = lnk_cnt_q == LINK_TK;
    cond[EV_MOD]  = I_MOD_FLT;
    cond[EV_MCU]  = I_MCU_FLT;
    cond[EV_UV]   = I_UNDERVOLT;
    cond[EV_DEAC] = deact_q;
    cond[EV_ISO]  = cfg_q.isolate;
  end

  // latch events; a state reset only clears when all causes are gone
  assign accept = (key_q | ext_req_q) & (|ev_q) & ~(|(cond & ev_q));
  assign clr    = accept ? ev_q : 16'h0;
  assign ev_d   = restart_q ? 16'h0 : ((ev_q & ~clr) | cond);
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ev_q   <= '0;
      pend_q <= '0;
    end else begin
      ev_q   <= ev_d;
      pend_q <= (pend_q & ~(pk_any ? (16'h1 << pk_idx) : 16'h0)) | (ev_d & ~ev_q);
    end
  end

  // pending new events go out one per cycle, lowest bit first whatever its age
  always_comb begin
    pk_idx = '0;
    pk_any = |pend_q;
    for (int i = 15; i >= 0; i--) begin
      if (pend_q[i]) begin
        pk_idx = 4'(i);
      end
    end
  end

  // rolling event memory, newest at position one
  always_ff @(posedge I_CLK) begin
    if (pk_any) begin
      mem[wp_q] <= {EVT_CODE_HI, pk_idx};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wp_q   <= '0;
      ecnt_q <= '0;
    end else begin
      if (pk_any) begin
        wp_q <= (wp_q == EVT_DEPTH - 10'h1) ? 10'h0 : wp_q + 10'h1;
      end
      if (erase_q) begin
        ecnt_q <= pk_any ? 10'h1 : 10'h0;
      end else if (pk_any & (ecnt_q != EVT_DEPTH)) begin
        ecnt_q <= ecnt_q + 10'h1;
      end
    end
  end

  // event file stream to the card
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_EVT_STB  <= 1'b0;
      O_EVT_CODE <= '0;
      O_EVT_FILE <= '0;
      evf_cnt_q  <= '0;
    end else begin
      O_EVT_STB <= pk_any;
      if (pk_any) begin
        O_EVT_CODE <= {EVT_CODE_HI, pk_idx};
        if (evf_cnt_q == EVT_ENTRY - 16'h1) begin
          evf_cnt_q  <= '0;
          O_EVT_FILE <= (O_EVT_FILE == EVT_FILES - 4'h1) ? 4'h0 : O_EVT_FILE + 4'h1;
        end else begin
          evf_cnt_q <= evf_cnt_q + 16'h1;
        end
      end
    end
  end

  // measurement log, one entry per second
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_LOG_STB  <= 1'b0;
      O_LOG_FILE <= '0;
      log_cnt_q  <= '0;
    end else begin
      O_LOG_STB <= sec_q;
      if (sec_q) begin
        if (log_cnt_q == LOG_ENTRY - 15'h1) begin
          log_cnt_q  <= '0;
          O_LOG_FILE <= (O_LOG_FILE == LOG_FILES - 8'h1) ? 8'h0 : O_LOG_FILE + 8'h1;
        end else begin
          log_cnt_q <= log_cnt_q + 15'h1;
        end
      end
    end
  end

  // relay and indicator drive
  assign fault = |(ev_q & FLT_MASK);
  assign iso   = cfg_q.isolate;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FLT_RELAY <= 1'b0;
      O_FLT_LED   <= 1'b0;
      O_OC_FLT    <= 1'b0;
      O_ALM_RELAY <= 1'b0;
      O_OC_ALM    <= 1'b0;
      O_LOOP_ALM  <= 1'b0;
      O_LOOP_PRE  <= '0;
    end else begin
      O_FLT_RELAY <= ~fault & ~restart_q;
      O_FLT_LED   <= fault | iso;
      O_OC_FLT    <= fault;
      O_ALM_RELAY <= ev_q[EV_ALM] & ~iso;
      O_OC_ALM    <= ev_q[EV_ALM] & ~iso;
      O_LOOP_ALM  <= ev_q[EV_ALM] & ~iso;
      O_LOOP_PRE  <= ev_q[EV_PRE1 +: 3] & {3{~iso}};
    end
  end
endmodule // dsc_top
`default_nettype wire

// [tb/dsc_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// watches fault, alarm, fan and card-file outputs of the supervision block
module dsc_top_sva import dsc_pkg::*; #(
  parameter int unsigned P_TICK_CYC = TICK_CYC_DEF
) (
  input wire logic       I_CLK,
  input wire logic       I_RST_B,
  input wire logic       O_FLT_RELAY,
  input wire logic       O_FLT_LED,
  input wire logic       O_OC_FLT,
  input wire logic       O_ALM_RELAY,
  input wire logic       O_OC_ALM,
  input wire logic       O_FAN_RUN,
  input wire logic [7:0] O_FAN_SPD,
  input wire logic       O_LOG_STB,
  input wire logic [7:0] O_LOG_FILE,
  input wire logic [3:0] O_EVT_FILE
);
  int unsigned gap_q;
  logic        seen_q;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // cycles since the last log strobe
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= O_LOG_STB ? 0 : gap_q + 1;
      seen_q <= seen_q | O_LOG_STB;
    end
  end
  a_led_drops_relay: assert property ($rose(O_FLT_LED) |-> ##[0:2] !O_FLT_RELAY)
    else $error("fault indicator lit, relay still energised");
  a_oc_drops_relay: assert property ($rose(O_OC_FLT) |-> ##[0:2] !O_FLT_RELAY)
    else $error("fault output set, relay still energised");
  a_restart_relay: assert property ($fell(O_FAN_RUN) |-> ##[0:1] !O_FLT_RELAY [*8])
    else $error("relay held during restart");
  a_fan_ramp: assert property (O_FAN_RUN && $past(O_FAN_RUN) |->
    O_FAN_SPD == $past(O_FAN_SPD) || O_FAN_SPD == $past(O_FAN_SPD) + 8'h01)
    else $error("fan speed jumped");
  a_alarm_agree: assert property (O_ALM_RELAY == O_OC_ALM)
    else $error("alarm relay and output disagree");
  a_log_period: assert property (O_LOG_STB && seen_q |-> gap_q >= SEC_TK * P_TICK_CYC - 1)
    else $error("log entries closer than one second");
  a_log_wrap: assert property ($changed(O_LOG_FILE) |->
    O_LOG_FILE == (($past(O_LOG_FILE) == LOG_FILES - 8'h01) ? 8'h00 : $past(O_LOG_FILE) + 8'h01))
    else $error("log file step wrong");
  a_evt_wrap: assert property ($changed(O_EVT_FILE) |->
    O_EVT_FILE == (($past(O_EVT_FILE) == EVT_FILES - 4'h1) ? 4'h0 : $past(O_EVT_FILE) + 4'h1))
    else $error("event file step wrong");
  c_alarm: cover property ($rose(O_ALM_RELAY));
  c_restart: cover property ($fell(O_FAN_RUN));
  c_log: cover property (O_LOG_STB && seen_q);
endmodule // dsc_top_sva
bind dsc_top dsc_top_sva #(.P_TICK_CYC(P_TICK_CYC)) u_sva (.*);
`default_nettype wire

// [tb/dsc_sns_model.sv]
`timescale 1ns/100ps
`default_nettype none
// sensor head: one status frame every P_GAP cycles unless muted
module dsc_sns_model import dsc_pkg::*; #(
  parameter int P_GAP = 200
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_mute,
  input  wire logic       i_elec,
  input  wire logic       i_dusty,
  input  wire logic [7:0] i_level,
  output var  dsc_sns_t   o_sns
);
  int cnt_q;
  // frame timer; level is scrambled outside frames
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 0;
      o_sns <= '0;
    end else begin
      cnt_q          <= (cnt_q == P_GAP - 1) ? 0 : cnt_q + 1;
      o_sns.valid    <= (cnt_q == 0) && !i_mute;
      o_sns.elec_flt <= i_elec;
      o_sns.dusty    <= i_dusty;
      o_sns.level    <= (cnt_q == 0) ? i_level : ~o_sns.level;
    end
  end
endmodule // dsc_sns_model
`default_nettype wire

// [tb/test_detector_supervision_controller.sv]
`timescale 1ns/100ps
`default_nettype none
module test_detector_supervision_controller
  import dsc_pkg::*;
();
  logic             clk, rst_b, awv, wv, bry, arv, rry, ext;
  logic [7:0]       awa, ara, lvl;
  logic [31:0]      wd, rdat;
  logic [1:0]       resp;
  logic [15:0]      air;
  logic [6:0]       cause;
  int               err_total = 0;
  int               n_compared = 0;
  wire logic        awr, wrd, bv, arr, rv, relay, led, alm, oca, fan, lalm;
  wire logic [2:0]  lpre;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdw;
  wire dsc_sns_t    sns;

  dsc_top #(.P_TICK_CYC(10)) dut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv),
    .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
    .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdw),
    .O_RRESP(rr), .I_EXT_RST(ext), .I_AIRFLOW(air), .I_SNS(sns), .I_FAN_FLT(cause[0]),
    .I_MOD_FLT(cause[1]), .I_MCU_FLT(cause[2]), .I_UNDERVOLT(cause[3]), .O_FLT_RELAY(relay),
    .O_FLT_LED(led), .O_OC_FLT(), .O_ALM_RELAY(alm), .O_OC_ALM(oca), .O_LOOP_ALM(lalm), .O_LOOP_PRE(lpre),
    .O_FAN_RUN(fan), .O_FAN_SPD(), .O_LOG_STB(), .O_LOG_FILE(), .O_EVT_STB(), .O_EVT_CODE(),
    .O_EVT_FILE());
  dsc_sns_model head (.i_clk(clk), .i_rst_b(rst_b), .i_mute(cause[6]), .i_elec(cause[4]),
    .i_dusty(cause[5]), .i_level(lvl), .o_sns(sns));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bus write; the answer is sampled at the negedge before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    @(posedge clk);
    {awv, wv, bry} <= 3'b111;
    {awa, wd} <= {a, d};
    rb = 1'b0;
    for (int n = 0; n < 50 && !rb; n++) begin
      @(negedge clk);
      {ra, rw, rb, resp} = {awr, wrd, bv, br};
      @(posedge clk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
      if (rb) bry <= 1'b0;
    end
    if (!rb) err_total++;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ra, rb;
    @(posedge clk);
    {arv, rry, ara} <= {2'b11, a};
    rb = 1'b0;
    for (int n = 0; n < 50 && !rb; n++) begin
      @(negedge clk);
      {ra, rb, rdat, resp} = {arr, rv, rdw, rr};
      @(posedge clk);
      if (ra) arv <= 1'b0;
      if (rb) rry <= 1'b0;
    end
    if (!rb) err_total++;
    @(negedge clk);
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(A_CMD, c);
    cyc(30);
  endtask
  task automatic t_boot();
    cyc(500);
    chk({fan, relay}, 2'b00);
    rd(A_AFCFG);
    chk(rdat, 32'h0001_2c14);
    wr(8'h3c, ERASE_KEY);
    chk(resp, 2'h2);
    cyc(700);
    rd(A_STAT);
    chk({relay, rdat[EV_INIT]}, 2'b01);
    cmd(32'h2);
    rd(A_AFREF);
    chk(rdat, 32'h0001_03e8);
    cmd(32'h1);
    chk({relay, led}, 2'b10);
  endtask
  task automatic t_air();
    wr(A_AFCFG, 32'h0000_0314);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) air <= i ? 16'd1210 : 16'd790;
      cyc(1900);
      chk(relay, 1'b1);
      cyc(1300);
      rd(A_STAT);
      chk({relay, rdat[EV_AFLO + i]}, 2'b01);
      cmd(32'h1);
      chk(relay, 1'b0);
      @(posedge clk) air <= 16'd1000;
      cyc(10);
      cmd(32'h1);
      chk(relay, 1'b1);
    end
  endtask
  task automatic t_alarm();
    @(posedge clk) lvl <= 8'h70;
    cyc(500);
    rd(A_STAT);
    chk(rdat[3:0], 4'h6);
    @(posedge clk) lvl <= 8'hd0;
    cyc(500);
    chk(alm, 1'b1);
    chk({lalm, lpre}, 4'hf);
    @(posedge clk) lvl <= 8'h10;
    cyc(500);
    cmd(32'h1);
    wr(A_CTRL, 32'h1);
    cyc(30);
    chk({relay, led}, 2'b01);
    @(posedge clk) lvl <= 8'hd0;
    cyc(500);
    rd(A_STAT);
    chk({rdat[EV_ALM], alm, oca, lalm, lpre}, 7'h40);
    @(posedge clk) lvl <= 8'h10;
    wr(A_CTRL, 32'h0);
    cyc(500);
    cmd(32'h1);
    chk(relay, 1'b1);
  endtask
  task automatic t_faults();
    int evb [7] = '{EV_FAN, EV_MOD, EV_MCU, EV_UV, EV_SELE, EV_SDST, EV_LINK};
    for (int k = 0; k < 7; k++) begin
      @(posedge clk) cause <= 7'(1 << k);
      cyc(k == 6 ? 5500 : 500);
      rd(A_STAT);
      chk({relay, rdat[evb[k]]}, 2'b01);
      @(posedge clk) cause <= 7'h0;
      cyc(500);
      cmd(32'h1);
      chk(relay, 1'b1);
    end
    wr(A_ERASE, ~ERASE_KEY);
    rd(A_EVDAT);
    chk(rdat, {23'h0, 1'b1, EVT_CODE_HI, 4'ha});
    wr(A_ERASE, ERASE_KEY);
    rd(A_EVCNT);
    chk(rdat, 32'h0);
  endtask
  task automatic t_restart();
    cmd(32'h4);
    cyc(470);
    chk({fan, relay}, 2'b00);
    cyc(800);
    chk(fan, 1'b1);
    rd(A_AFCFG);
    chk(rdat, 32'h0000_0314);
    rd(A_AFREF);
    chk(rdat, 32'h0001_03e8);
  endtask
  task automatic t_ext();
    int len [3] = '{400, 15000, 600};
    @(posedge clk) cause <= 7'h1;
    cyc(20);
    @(posedge clk) cause <= 7'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) ext <= 1'b1;
      cyc(len[i]);
      @(posedge clk) ext <= 1'b0;
      cyc(40);
      chk(relay, i == 2);
    end
    for (int f = 0; f < 2; f++) begin
      wr(A_CTRL, 32'(f * 2));
      @(posedge clk) ext <= 1'b1;
      cyc(20500);
      rd(A_STAT);
      chk({relay, rdat[EV_DEAC]}, f ? 2'b10 : 2'b01);
      @(posedge clk) ext <= 1'b0;
      cyc(40);
      cmd(32'h1);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence: reset for 10 cycles, then the scenarios
  initial begin
    {rst_b, awv, wv, bry, arv, rry, ext, awa, ara, wd, cause} = '0;
    {air, lvl} = {16'd1000, 8'h10};
    cyc(10);
    @(posedge clk) rst_b <= 1'b1;
    t_boot();
    t_air();
    t_alarm();
    t_faults();
    t_restart();
    t_ext();
    conclude();
  end
  // watchdog: the scenarios need about 0.82 ms
  initial begin
    #950000;
    err_total++;
    conclude();
  end
endmodule // test_detector_supervision_controller
`default_nettype wire
